/* File: ebcp_seq.sv */
`timescale 1ns/10ps
module ebcp_seq
  import ebcp_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [CS_W-1:0] req_cs,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic req_new_window,
  // per chip select timing: {hs_en, rdy_async, x, ab, c, d, e, spare[1:0], rdy_low, f}
  input wire logic [NUM_CS*18-1:0] chip_select_timing_config,
  // status
  output logic busy,
  output logic done,
  output logic [DATA_W-1:0] rd_data,
  // bus pins
  input wire logic ready_pin,
  input wire logic [DATA_W-1:0] data_in,
  output logic [ADDR_W-1:0] addr_out,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  output logic [NUM_CS-1:0] cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic external_clock_output_en,
  output logic clk_sel_sys
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic ready_s;
  logic ready_s2_r;
  logic [DATA_W-1:0] din_s;
  ebcp_sync u_rdy (.sys_clk(sys_clk), .arst_n(arst_n), .async_in(ready_pin),
    .sync_out(ready_s));
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_din
      ebcp_sync u_d (.sys_clk(sys_clk), .arst_n(arst_n), .async_in(data_in[gi]),
        .sync_out(din_s[gi]));
    end
  endgenerate

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  ebcp_state_t st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [17:0] cfg_r, cfg_nxt;
  logic wr_r, wr_nxt, nw_r, nw_nxt, busy_r, busy_nxt, done_r, done_nxt;
  logic rd_n_r, rd_n_nxt, wr_n_r, wr_n_nxt, oe_r, oe_nxt;
  logic [CS_W-1:0] cs_r, cs_nxt;
  logic [NUM_CS-1:0] cs_n_r, cs_n_nxt;
  logic [ADDR_W-1:0] a_r, a_nxt;
  logic [DATA_W-1:0] d_r, d_nxt, rd_r, rd_nxt;
  logic [17:0] sel_cfg;
  logic [CNT_W-1:0] ab_len, c_len, d_len, e_len, f_len;
  logic rdy_raw, rdy_act;

  assign sel_cfg = chip_select_timing_config[req_cs*18 +: 18];
  // lengths of the latched configuration, whole periods
  assign ab_len = CNT_W'(cfg_r[13]) + 5'h01 + (nw_r ? CNT_W'(cfg_r[15:14]) : 5'h00);
  assign c_len = CNT_W'(cfg_r[12:11]);
  assign d_len = CNT_W'(cfg_r[10]);
  assign e_len = CNT_W'(cfg_r[9:5]); // index of last access period, 32 would not fit
  assign f_len = CNT_W'(cfg_r[1:0]);
  // async ready takes one more stage, hence one more wait state
  assign rdy_raw = cfg_r[16] ? ready_s2_r : ready_s;
  assign rdy_act = rdy_raw ^ cfg_r[2];

  // next-phase selection skipping zero-length phases
  function automatic ebcp_state_t after_addr(input logic [CNT_W-1:0] cl, dl);
    if (cl != 5'h00) return EBCP_CMD;
    else if (dl != 5'h00) return EBCP_WSETUP;
    else return EBCP_ACCESS;
  endfunction

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r + 5'h01;
    cfg_nxt = cfg_r;
    wr_nxt = wr_r;
    nw_nxt = nw_r;
    cs_nxt = cs_r;
    a_nxt = a_r;
    d_nxt = d_r;
    rd_nxt = rd_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    rd_n_nxt = rd_n_r;
    wr_n_nxt = wr_n_r;
    oe_nxt = oe_r;
    cs_n_nxt = cs_n_r;
    unique case (st_r)
      EBCP_IDLE: begin
        cnt_nxt = CNT_RST;
        if (req_valid) begin
          st_nxt = EBCP_ADDR;
          cfg_nxt = sel_cfg;
          wr_nxt = req_write;
          nw_nxt = req_new_window;
          cs_nxt = req_cs;
          a_nxt = req_addr;
          d_nxt = req_wdata;
          busy_nxt = 1'b1;
          cs_n_nxt = ~(NUM_CS'(1) << req_cs);
        end
      end
      EBCP_ADDR: begin
        if (cnt_r + 5'h01 >= ab_len) begin
          cnt_nxt = CNT_RST;
          st_nxt = after_addr(c_len, d_len);
          oe_nxt = wr_r;
          if (st_nxt == EBCP_ACCESS) begin
            rd_n_nxt = wr_r;
            wr_n_nxt = ~wr_r;
          end
        end
      end
      EBCP_CMD: begin
        if (cnt_r + 5'h01 >= c_len) begin
          cnt_nxt = CNT_RST;
          st_nxt = (d_len != 5'h00) ? EBCP_WSETUP : EBCP_ACCESS;
          if (d_len == 5'h00) begin
            rd_n_nxt = wr_r;
            wr_n_nxt = ~wr_r;
          end
        end
      end
      EBCP_WSETUP: begin
        cnt_nxt = CNT_RST;
        st_nxt = EBCP_ACCESS;
        rd_n_nxt = wr_r;
        wr_n_nxt = ~wr_r;
      end
      EBCP_ACCESS: begin
        if (cnt_r >= e_len) begin
          cnt_nxt = cnt_r;
          // sample ready after the programmed access length
          if (!cfg_r[17] || rdy_act) begin
            cnt_nxt = CNT_RST;
            rd_n_nxt = 1'b1;
            wr_n_nxt = 1'b1;
            if (!wr_r) begin
              rd_nxt = din_s;
            end
            if (f_len != 5'h00) begin
              st_nxt = EBCP_HOLD;
            end else begin
              st_nxt = EBCP_IDLE;
              busy_nxt = 1'b0;
              done_nxt = 1'b1;
              oe_nxt = 1'b0;
              cs_n_nxt = '1;
            end
          end
        end
      end
      EBCP_HOLD: begin
        if (cnt_r + 5'h01 >= f_len) begin
          cnt_nxt = CNT_RST;
          st_nxt = EBCP_IDLE;
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
          oe_nxt = 1'b0;
          cs_n_nxt = '1;
        end
      end
      default: st_nxt = EBCP_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= EBCP_IDLE;
      cnt_r <= CNT_RST;
      cfg_r <= '0;
      wr_r <= 1'b0;
      nw_r <= 1'b0;
      cs_r <= '0;
      a_r <= '0;
      d_r <= '0;
      rd_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      oe_r <= 1'b0;
      cs_n_r <= '1;
      ready_s2_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      cfg_r <= cfg_nxt;
      wr_r <= wr_nxt;
      nw_r <= nw_nxt;
      cs_r <= cs_nxt;
      a_r <= a_nxt;
      d_r <= d_nxt;
      rd_r <= rd_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      rd_n_r <= rd_n_nxt;
      wr_n_r <= wr_n_nxt;
      oe_r <= oe_nxt;
      cs_n_r <= cs_n_nxt;
      ready_s2_r <= ready_s;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // reference clock is the system clock itself; these only steer the pin mux
  logic clk_en_r;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_en_r <= 1'b0;
    end else begin
      clk_en_r <= 1'b1;
    end
  end
  assign external_clock_output_en = clk_en_r;
  assign clk_sel_sys = clk_en_r;
  assign busy = busy_r;
  assign done = done_r;
  assign rd_data = rd_r;
  assign addr_out = a_r;
  assign data_out = d_r;
  assign data_oe = oe_r;
  assign cs_n = cs_n_r;
  assign rd_n = rd_n_r;
  assign wr_n = wr_n_r;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_order;
    @(posedge sys_clk) disable iff (!arst_n)
      (st_r == EBCP_ACCESS && st_nxt != st_r) |-> (st_nxt == EBCP_HOLD || st_nxt == EBCP_IDLE);
  endproperty
  a_order: assert property (p_order) else $error("access not followed by hold or idle");
  property p_strobe;
    @(posedge sys_clk) disable iff (!arst_n)
      (st_r == EBCP_ACCESS) |-> (rd_n_r != wr_n_r);
  endproperty
  a_strobe: assert property (p_strobe) else $error("no single strobe in access");
  property p_hold;
    @(posedge sys_clk) disable iff (!arst_n)
      (st_r == EBCP_HOLD) |-> (rd_n_r && wr_n_r && !cs_n_r[cs_r]);
  endproperty
  a_hold: assert property (p_hold) else $error("hold phase lost chip select");
  property p_ready;
    @(posedge sys_clk) disable iff (!arst_n)
      (st_r == EBCP_ACCESS && cfg_r[17] && !rdy_act) |=> (st_r == EBCP_ACCESS);
  endproperty
  a_ready: assert property (p_ready) else $error("access ended without ready");
  property p_done;
    @(posedge sys_clk) disable iff (!arst_n)
      done_r |-> (!busy_r && cs_n_r == '1 && st_r == EBCP_IDLE);
  endproperty
  a_done: assert property (p_done) else $error("done while cycle active");
  property p_abmin;
    @(posedge sys_clk) disable iff (!arst_n)
      (st_r == EBCP_IDLE && req_valid) |=> (st_r == EBCP_ADDR);
  endproperty
  a_abmin: assert property (p_abmin) else $error("address phase skipped");
  property p_rdcap;
    @(posedge sys_clk) disable iff (!arst_n)
      ($rose(rd_n_r)) |-> (rd_r == $past(din_s));
  endproperty
  a_rdcap: assert property (p_rdcap) else $error("read data not captured at strobe end");
  property p_clk;
    @(posedge sys_clk) disable iff (!arst_n)
      busy_r |-> external_clock_output_en;
  endproperty
  a_clk: assert property (p_clk) else $error("reference clock driver off");
endmodule

/* File: ebcp_pkg.sv */
package ebcp_pkg;
  // phase length fields
  localparam int AB_W = 1;       // address setup base: 0 -> 1 period, 1 -> 2 periods
  localparam int C_W = 2;        // command delay 0..3
  localparam int D_W = 1;        // write setup / tristate 0..1
  localparam int E_W = 5;        // access, code+1 periods: 1..32
  localparam int F_W = 2;        // hold 0..3
  localparam int X_W = 2;        // window-change extension 0..3
  localparam int CNT_W = 5;
  localparam int NUM_CS = 4;
  localparam int CS_W = 2;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
  localparam logic [1:0] SYNC_RST = 2'h0;
  typedef enum logic [2:0] {
    EBCP_IDLE, EBCP_ADDR, EBCP_CMD, EBCP_WSETUP, EBCP_ACCESS, EBCP_HOLD
  } ebcp_state_t;
endpackage

/* File: ebcp_sync.sv */
`timescale 1ns/10ps
module ebcp_sync
  import ebcp_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // async level in, synchronised out
  input wire logic async_in,
  output logic sync_out
);
  logic [1:0] stage_r;
  logic [1:0] stage_nxt;

  always_comb begin
    stage_nxt = {stage_r[0], async_in};
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage_r <= SYNC_RST;
    end else begin
      stage_r <= stage_nxt;
    end
  end

  assign sync_out = stage_r[1];
endmodule

/* File: ebcp_mem_model.sv */
`timescale 1ns/10ps
module ebcp_mem_model
  import ebcp_pkg::*;
(
  // link clock
  input wire logic lclk,
  // bus from the sequencer
  input wire logic [ADDR_W-1:0] addr_out,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic [NUM_CS-1:0] cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  // lag of ready in link periods, zero means at once
  input wire logic [1:0] rdy_dly,
  // answers
  output logic ready_pin,
  output logic [DATA_W-1:0] data_in
);
  logic [DATA_W-1:0] mem [16];
  logic [DATA_W-1:0] last;
  logic [1:0] cnt;
  initial begin
    last = 16'h0000;
    cnt = 2'h0;
    ready_pin = 1'b0;
  end
  always @(posedge wr_n) mem[addr_out[3:0]] = data_out;
  always @(posedge rd_n) last = mem[addr_out[3:0]];
  // released bus shows the inverse, never a stale copy
  always_comb data_in = (cs_n != 4'hf && wr_n) ? mem[addr_out[3:0]] : ~last;
  always @(negedge rd_n or negedge wr_n) begin
    cnt = rdy_dly;
    if (cnt == 2'h0) ready_pin = 1'b1;
  end
  always @(posedge lclk) begin
    if (!(rd_n && wr_n) && cnt != 2'h0) begin
      cnt = cnt - 2'h1;
      if (cnt == 2'h0) ready_pin = 1'b1;
    end
  end
  always @(posedge rd_n or posedge wr_n) ready_pin = 1'b0;
endmodule

/* File: test_ebcp_seq.sv */
`timescale 1ns/10ps
module test_ebcp_seq
  import ebcp_pkg::*;
;
  logic sys_clk, arst_n, lclk, req_valid, req_write, req_new_window, ready_pin;
  logic rdy_m, rdy_inv;
  logic busy, done, data_oe, rd_n, wr_n, ext_en, clk_sys;
  logic [CS_W-1:0] req_cs;
  logic [ADDR_W-1:0] req_addr, addr_out;
  logic [DATA_W-1:0] req_wdata, rd_data, data_in, data_out;
  logic [NUM_CS*18-1:0] cfg;
  logic [NUM_CS-1:0] cs_n;
  logic [1:0] rdy_dly;
  int err_total, n_compared;

  ebcp_seq uut (.sys_clk(sys_clk), .arst_n(arst_n), .req_valid(req_valid),
    .req_write(req_write), .req_cs(req_cs), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_new_window(req_new_window), .chip_select_timing_config(cfg), .busy(busy),
    .done(done), .rd_data(rd_data), .ready_pin(ready_pin), .data_in(data_in),
    .addr_out(addr_out), .data_out(data_out), .data_oe(data_oe), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .external_clock_output_en(ext_en), .clk_sel_sys(clk_sys));
  ebcp_mem_model u_mem (.lclk(lclk), .addr_out(addr_out), .data_out(data_out),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .rdy_dly(rdy_dly), .ready_pin(rdy_m),
    .data_in(data_in));
  // inverted pin for the active-low ready scenario
  assign ready_pin = rdy_m ^ rdy_inv;

  // ----------
  // helpers
  // ----------
  function automatic logic [17:0] mk(input logic hs, as, pl, input logic [1:0] x,
      input logic ab, input logic [1:0] c, input logic d, input logic [4:0] e,
      input logic [1:0] f);
    return {hs, as, x, ab, c, d, e, 2'h0, pl, f};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // one bus cycle; for reads wd is the word expected back
  task automatic run(input logic [1:0] cs, input logic w, input logic [23:0] a,
      input logic [15:0] wd, input logic nw, output int s);
    logic [17:0] c;
    int n, fix;
    c = cfg[cs*18 +: 18];
    fix = 1 + c[13] + (nw ? c[15:14] : 0) + c[12:11] + c[10] + c[1:0];
    n = 0;
    s = 0;
    @(posedge sys_clk);
    req_cs <= cs;
    req_write <= w;
    req_addr <= a;
    req_wdata <= w ? wd : 16'h0000;
    req_new_window <= nw;
    req_valid <= 1'b1;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    while (done !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      #1;
      n++;
      if (rd_n === 1'b0 || wr_n === 1'b0) begin
        s++;
        if (s == 1) begin
          chk("addr", a, addr_out);
          chk("cs_n", 4'(~(4'h1 << cs)), cs_n);
          chk("dir", {w, !w}, {~wr_n, ~rd_n});
          chk("busy", 1, busy);
          if (w) chk("wdata", {1'b1, wd}, {data_oe, data_out});
          else chk("oe", 0, data_oe);
        end
      end
    end
    chk("total", fix + s, n);
    chk("busy end", 0, busy);
    if (!c[17]) chk("strobe", c[9:5] + 1, s);
    if (!w) chk("rd_data", wd, rd_data);
  endtask

  // ----------
  // clocks and run
  // ----------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    lclk = 1'b0;
    #3;
    forever #40 lclk = ~lclk;
  end
  initial begin
    #200000;
    err_total++;
    conclude();
  end
  initial begin
    int s1, s2;
    err_total = 0;
    n_compared = 0;
    arst_n = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_cs = 2'h0;
    req_addr = 24'h000000;
    req_wdata = 16'h0000;
    req_new_window = 1'b0;
    rdy_dly = 2'h0;
    rdy_inv = 1'b0;
    cfg = {mk(1, 1, 0, 2, 0, 1, 0, 5'h00, 2), mk(1, 0, 0, 2, 0, 1, 0, 5'h00, 2),
      mk(0, 0, 0, 3, 1, 3, 1, 5'h1f, 3), mk(0, 0, 0, 0, 0, 0, 0, 5'h01, 0)};
    repeat (3) @(posedge sys_clk);
    chk("reset idle", 6'h3f, {cs_n, rd_n, wr_n});
    arst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk("bus_reference_clock_out", 2'h3, {ext_en, clk_sys});
    for (int cs = 0; cs < 2; cs++) begin
      for (int nw = 0; nw < 2; nw++) begin
        run(2'(cs), 1'b1, 24'h120000 | 24'(cs * 4 + nw), 16'h5a00 | 16'(cs * 4 + nw),
          1'(nw), s1);
        run(2'(cs), 1'b0, 24'h120000 | 24'(cs * 4 + nw), 16'h5a00 | 16'(cs * 4 + nw),
          1'(nw), s1);
      end
    end
    run(2'h2, 1'b1, 24'h000008, 16'hc3a5, 1'b0, s1);
    run(2'h2, 1'b0, 24'h000008, 16'hc3a5, 1'b1, s1);
    run(2'h3, 1'b0, 24'h000008, 16'hc3a5, 1'b0, s2);
    chk("ready wait", 1, s1 > 1);
    chk("async stage", s1 + 1, s2);
    // same handshake with ready active low: same wait count expected
    @(posedge sys_clk);
    cfg[2 * 18 + 2] <= 1'b1;
    rdy_inv <= 1'b1;
    run(2'h2, 1'b0, 24'h000008, 16'hc3a5, 1'b1, s2);
    chk("ready low", s1, s2);
    rdy_dly <= 2'h2;
    run(2'h2, 1'b0, 24'h000008, 16'hc3a5, 1'b0, s1);
    chk("stretch", 1, s1 >= 9 && s1 <= 24);
    conclude();
  end
endmodule
